// *** logic/cbh_console.sv ***
`timescale 1ns/100ps
`include "cbh_map.svh"

module cbh_console #(
   parameter int TICK_CYCLES = `CBH_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`CBH_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Front-panel buttons
   input  wire logic                   main_button,
   input  wire logic                   talkback_button,
   // Configuration switches
   input  wire logic                   mono_headphone_select,
   input  wire logic                   main_button_mode_bit_a,
   input  wire logic                   main_button_mode_bit_b,
   input  wire logic                   talkback_button_mode_select,
   input  wire logic                   control_pairing_select,
   input  wire logic                   orientation_reverse_select,
   input  wire logic                   minimum_level_select,
   // Rotary control positions, zero is fully counterclockwise
   input  wire logic [7:0]             pot_left,
   input  wire logic [7:0]             pot_right,
   // Cue audio in
   input  wire logic                   cue_valid,
   input  wire logic signed [15:0]     cue_left,
   input  wire logic signed [15:0]     cue_right,
   // Headphone audio out
   output logic                        hp_valid,
   output logic signed [15:0]          hp_left,
   output logic signed [15:0]          hp_right,
   // Channel decisions
   output logic                        main_active,
   output logic                        talkback_active
);

   logic [6:0]             sw1_reg, sw2_reg, sw3_reg, sw_reg;
   logic [`CBH_MAP_W-1:0]  map_reg;
   logic [`CBH_TAP_W-1:0]  tap_reg;
   logic [31:0]            tick_cnt_reg;
   logic                   tick_reg;
   logic                   mb_held, mb_press, mb_tap, mb_long;
   logic                   tb_held, tb_press, tb_tap, tb_long;
   logic                   main_state_reg, main_prior_reg;
   logic                   tb_state_reg, tb_prior_reg;
   cbh_pkg::cbh_main_mode_e mmode;
   logic                   tb_hyb, pair_bal, rev_on, lim_on, mono_on;
   cbh_pkg::cbh_gain_t     bal_l, bal_r, gl_next, gr_next;
   cbh_pkg::cbh_gain_t     gain_l_reg, gain_r_reg;
   logic signed [15:0]     sl, sr;
   logic                   acc_wr, setup;
   logic [31:0]            rd_next;
   logic                   err_next;

   // Product of two gains, full scale near unity
   function automatic cbh_pkg::cbh_gain_t scale(input logic [7:0] a,
                                                input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b);
      return p[15:8];
   endfunction

   // Sample times gain
   function automatic logic signed [15:0] apply(
         input logic signed [15:0] s, input logic [7:0] g);
      logic signed [24:0] p;
      p = s * $signed({1'b0, g});
      return p[23:8];
   endfunction

   // Saturating sum of two samples
   function automatic logic signed [15:0] sat_add(
         input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      if (s > 17'sh07FFF) begin
         return 16'sh7FFF;
      end else if (s < -17'sh08000) begin
         return 16'sh8000;
      end
      return s[15:0];
   endfunction

   // Raise a gain to the floor when limited minimum is on
   function automatic cbh_pkg::cbh_gain_t floor_g(input logic [7:0] g,
                                                  input logic lim);
      return (lim && g < `CBH_FLOOR_GAIN) ? `CBH_FLOOR_GAIN : g;
   endfunction

   // Switch synchroniser: a change counts when stages two and three agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         sw1_reg <= 7'h00;
         sw2_reg <= 7'h00;
         sw3_reg <= 7'h00;
         sw_reg  <= 7'h00;
      end else begin
         sw1_reg <= {mono_headphone_select, minimum_level_select,
                     orientation_reverse_select, control_pairing_select,
                     talkback_button_mode_select, main_button_mode_bit_b,
                     main_button_mode_bit_a};
         sw2_reg <= sw1_reg;
         sw3_reg <= sw2_reg;
         if (sw2_reg == sw3_reg) begin
            sw_reg <= sw3_reg;
         end
      end
   end

   // Millisecond tick enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg     <= 1'b0;
      end
   end

   // Button conditioning
   cbh_button u_main_btn (
      .mclk      (mclk),
      .reset     (reset),
      .tick      (tick_reg),
      .tap_ticks (tap_reg),
      .btn_pin   (main_button),
      .held      (mb_held),
      .press     (mb_press),
      .rel_tap   (mb_tap),
      .rel_long  (mb_long)
   );

   cbh_button u_tb_btn (
      .mclk      (mclk),
      .reset     (reset),
      .tick      (tick_reg),
      .tap_ticks (tap_reg),
      .btn_pin   (talkback_button),
      .held      (tb_held),
      .press     (tb_press),
      .rel_tap   (tb_tap),
      .rel_long  (tb_long)
   );

   // Mode decode through the software map
   always_comb begin
      logic [1:0] code;
      code = sw_reg[1:0];
      if (code == map_reg[`CBH_MAP_PTM_LSB +: 2]) begin
         mmode = cbh_pkg::CBH_PTM;
      end else if (code == map_reg[`CBH_MAP_ALT_LSB +: 2]) begin
         mmode = cbh_pkg::CBH_ALT;
      end else if (code == map_reg[`CBH_MAP_HYB_LSB +: 2]) begin
         mmode = cbh_pkg::CBH_HYB;
      end else begin
         mmode = cbh_pkg::CBH_PTT;
      end
      tb_hyb   = sw_reg[2] ^ map_reg[`CBH_MAP_INV_TB];
      pair_bal = sw_reg[3] ^ map_reg[`CBH_MAP_INV_PAIR];
      rev_on   = sw_reg[4] ^ map_reg[`CBH_MAP_INV_REV];
      lim_on   = sw_reg[5] ^ map_reg[`CBH_MAP_INV_LIM];
      mono_on  = sw_reg[6] ^ map_reg[`CBH_MAP_INV_MONO];
   end

   // Main latched state for alternate and hybrid
   always_ff @(posedge mclk) begin
      if (reset) begin
         main_state_reg <= 1'b0;
         main_prior_reg <= 1'b0;
      end else begin
         unique case (mmode)
            cbh_pkg::CBH_ALT: begin
               if (mb_press) begin
                  main_state_reg <= !main_state_reg;
               end
            end
            cbh_pkg::CBH_HYB: begin
               if (mb_press) begin
                  main_prior_reg <= main_state_reg;
                  main_state_reg <= 1'b1;
               end else if (mb_tap) begin
                  main_state_reg <= !main_prior_reg;
               end else if (mb_long) begin
                  main_state_reg <= 1'b0;
               end
            end
            cbh_pkg::CBH_PTM, cbh_pkg::CBH_PTT: begin
               main_state_reg <= 1'b0;
            end
         endcase
      end
   end

   // Main channel decision
   always_ff @(posedge mclk) begin
      if (reset) begin
         main_active <= 1'b0;
      end else begin
         unique case (mmode)
            cbh_pkg::CBH_PTM: main_active <= !mb_held;
            cbh_pkg::CBH_PTT: main_active <= mb_held;
            cbh_pkg::CBH_ALT, cbh_pkg::CBH_HYB: begin
               main_active <= main_state_reg;
            end
         endcase
      end
   end

   // Talkback latched state and decision
   always_ff @(posedge mclk) begin
      if (reset) begin
         tb_state_reg    <= 1'b0;
         tb_prior_reg    <= 1'b0;
         talkback_active <= 1'b0;
      end else if (tb_hyb) begin
         if (tb_press) begin
            tb_prior_reg <= tb_state_reg;
            tb_state_reg <= 1'b1;
         end else if (tb_tap) begin
            tb_state_reg <= !tb_prior_reg;
         end else if (tb_long) begin
            tb_state_reg <= 1'b0;
         end
         talkback_active <= tb_state_reg;
      end else begin
         tb_state_reg    <= 1'b0;
         talkback_active <= tb_held;
      end
   end

   // Headphone gains from controls and modes
   always_comb begin
      bal_l = (pot_right < `CBH_BAL_MID) ? `CBH_GAIN_FULL
            : {~pot_right[6:0], 1'b0}; // Twice 255 minus position
      bal_r = (pot_right >= `CBH_BAL_MID) ? `CBH_GAIN_FULL
            : {pot_right[6:0], 1'b0};
      if (pair_bal) begin
         gl_next = scale(pot_left, rev_on ? bal_r : bal_l);
         gr_next = scale(pot_left, rev_on ? bal_l : bal_r);
      end else begin
         gl_next = rev_on ? pot_right : pot_left;
         gr_next = rev_on ? pot_left : pot_right;
      end
   end

   // Gain registers with minimum-level floor
   always_ff @(posedge mclk) begin
      if (reset) begin
         gain_l_reg <= 8'h00;
         gain_r_reg <= 8'h00;
      end else begin
         gain_l_reg <= floor_g(gl_next, lim_on);
         gain_r_reg <= floor_g(gr_next, lim_on);
      end
   end

   assign sl = apply(cue_left, gain_l_reg);
   assign sr = apply(cue_right, gain_r_reg);

   // Headphone sample path
   always_ff @(posedge mclk) begin
      if (reset) begin
         hp_valid <= 1'b0;
         hp_left  <= 16'sh0000;
         hp_right <= 16'sh0000;
      end else begin
         hp_valid <= cue_valid;
         if (cue_valid) begin
            hp_left  <= mono_on ? sat_add(sl, sr) : sl;
            hp_right <= mono_on ? sat_add(sl, sr) : sr;
         end
      end
   end

   // APB decode; no wait state, answer registered at setup
   assign setup  = psel && !penable;
   assign acc_wr = psel && penable && pready && pwrite;

   always_comb begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      unique case (paddr)
         `CBH_REG_MAP: rd_next = 32'(map_reg);
         `CBH_REG_TAP: rd_next = 32'(tap_reg);
         `CBH_REG_STAT: begin
            err_next = pwrite;
            rd_next  = {gain_r_reg, gain_l_reg, 5'h00, sw_reg,
                        tb_held, mb_held, talkback_active, main_active};
         end
         default: err_next = 1'b1;
      endcase
   end

   // APB answer
   always_ff @(posedge mclk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && err_next;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_next;
         end
      end
   end

   // Writable registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         map_reg <= `CBH_MAP_RESET;
         tap_reg <= `CBH_TAP_RESET;
      end else if (acc_wr && paddr == `CBH_REG_MAP) begin
         map_reg <= pwdata[`CBH_MAP_W-1:0];
      end else if (acc_wr && paddr == `CBH_REG_TAP) begin
         tap_reg <= pwdata[`CBH_TAP_W-1:0];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   AST_PTM_MUTE: assert property (
      (mmode == cbh_pkg::CBH_PTM) |=> (main_active == !$past(mb_held)))
      else $error("main not muted while held in push to mute");
   AST_PTT_TALK: assert property (
      (mmode == cbh_pkg::CBH_PTT) |=> (main_active == $past(mb_held)))
      else $error("main not following button in push to talk");
   AST_ALT_TOGGLE: assert property (
      (mmode == cbh_pkg::CBH_ALT && mb_press)
      |=> (main_state_reg != $past(main_state_reg)))
      else $error("alternate press did not toggle");
   AST_HYB_TAP: assert property (
      (mmode == cbh_pkg::CBH_HYB && mb_tap)
      |=> (main_state_reg == !$past(main_prior_reg)))
      else $error("hybrid tap did not toggle");
   AST_TB_PTT: assert property (
      !tb_hyb |=> (talkback_active == $past(tb_held)))
      else $error("talkback not following button");
   AST_TB_HYB_HOLD: assert property (
      (tb_hyb && tb_press) ##1 tb_hyb |=> talkback_active)
      else $error("talkback hybrid press not active");
   AST_FLOOR: assert property (
      lim_on |=> (gain_l_reg >= `CBH_FLOOR_GAIN
                   && gain_r_reg >= `CBH_FLOOR_GAIN))
      else $error("headphone gain below floor");
   AST_FULL_MUTE: assert property (
      (!lim_on && !pair_bal && !rev_on && pot_left == 8'h00)
      |=> (gain_l_reg == 8'h00))
      else $error("fully down control did not mute");
   AST_MONO: assert property (
      (cue_valid && mono_on) |=> (hp_valid && hp_left == hp_right))
      else $error("mono outputs differ");
   AST_LEVEL_MAP: assert property (
      (!pair_bal && rev_on) |=> (gain_r_reg == floor_g($past(pot_left),
                                                      $past(lim_on))))
      else $error("reversed left control not on right channel");

   COV_HYB_TAP: cover property (mmode == cbh_pkg::CBH_HYB && mb_tap);
   COV_TB_LONG: cover property (tb_hyb && tb_long);
   COV_MONO:    cover property (cue_valid && mono_on);
   COV_MAP_WR:  cover property (acc_wr && paddr == `CBH_REG_MAP);

endmodule

// *** logic/cbh_map.svh ***
`ifndef CBH_MAP_SVH
`define CBH_MAP_SVH

// APB register byte offsets
`define CBH_ADDR_W        12
`define CBH_REG_MAP       12'h000
`define CBH_REG_TAP       12'h004
`define CBH_REG_STAT      12'h008

// Switch-code map register layout
`define CBH_MAP_W         13
`define CBH_MAP_RESET     13'h00E4
`define CBH_MAP_PTM_LSB   0
`define CBH_MAP_PTT_LSB   2
`define CBH_MAP_ALT_LSB   4
`define CBH_MAP_HYB_LSB   6
`define CBH_MAP_INV_TB    8
`define CBH_MAP_INV_PAIR  9
`define CBH_MAP_INV_REV   10
`define CBH_MAP_INV_LIM   11
`define CBH_MAP_INV_MONO  12

// Status register layout
`define CBH_STAT_SW_LSB   4
`define CBH_STAT_GL_LSB   16
`define CBH_STAT_GR_LSB   24

// Tap threshold, in millisecond ticks
`define CBH_TAP_W         16
`define CBH_TAP_RESET     16'h012C

// Timing
`define CBH_CLK_PERIOD_NS 10
`define CBH_TICK_TIME_NS  1000000
`define CBH_TICK_CYCLES   (`CBH_TICK_TIME_NS / `CBH_CLK_PERIOD_NS)
`define CBH_DEBOUNCE_MS   10

// Gain values; 40 dB down is 1/100 of full scale, rounded up
`define CBH_GAIN_FULL     8'hFF
`define CBH_BAL_MID       8'h80
`define CBH_FLOOR_GAIN    8'h03

`endif

// *** logic/cbh_pkg.sv ***
package cbh_pkg;

   // Main output button behaviours
   typedef enum logic [1:0] {
      CBH_PTM,
      CBH_PTT,
      CBH_ALT,
      CBH_HYB
   } cbh_main_mode_e;

   typedef logic [7:0] cbh_gain_t;

endpackage

// *** logic/cbh_button.sv ***
`timescale 1ns/100ps
`include "cbh_map.svh"

module cbh_button #(
   parameter int DEBOUNCE_TICKS = `CBH_DEBOUNCE_MS
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  reset,
   // Timing
   input  wire logic                  tick,
   input  wire logic [`CBH_TAP_W-1:0] tap_ticks,
   // Button pin
   input  wire logic                  btn_pin,
   // Decoded events
   output logic                       held,
   output logic                       press,
   output logic                       rel_tap,
   output logic                       rel_long
);

   logic                  s1_reg, s2_reg, s3_reg;
   logic [7:0]            deb_reg;
   logic [`CBH_TAP_W-1:0] hold_reg;

   // Three-stage synchroniser
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= btn_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Debounce: level must differ for the whole settle time
   always_ff @(posedge mclk) begin
      press    <= 1'b0;
      rel_tap  <= 1'b0;
      rel_long <= 1'b0;
      if (reset) begin
         held    <= 1'b0;
         deb_reg <= 8'h00;
      end else if (s2_reg != s3_reg || s3_reg == held) begin
         deb_reg <= 8'h00;
      end else if (tick) begin
         if (deb_reg == 8'(DEBOUNCE_TICKS - 1)) begin
            deb_reg  <= 8'h00;
            held     <= s3_reg;
            press    <= s3_reg;
            rel_tap  <= !s3_reg && (hold_reg < tap_ticks);
            rel_long <= !s3_reg && (hold_reg >= tap_ticks);
         end else begin
            deb_reg <= deb_reg + 8'h01;
         end
      end
   end

   // Press duration, saturating
   always_ff @(posedge mclk) begin
      if (reset || press) begin
         hold_reg <= '0;
      end else if (tick && held && hold_reg != '1) begin
         hold_reg <= hold_reg + 1'b1;
      end
   end

endmodule

// *** tb/cbh_panel_model.sv ***
`timescale 1ns/100ps
module cbh_panel_model (
   // Clock
   input  wire logic mclk,
   // Requested button levels from the bench
   input  wire logic main_req,
   input  wire logic talkback_req,
   // Button contacts towards the console
   output logic      main_button,
   output logic      talkback_button
);
   logic [1:0] req;
   logic [1:0] req_q;
   logic [1:0] pin;
   int         bounce [2];

   // Requests gathered into one vector
   assign req = {talkback_req, main_req};

   // Contacts start open
   initial begin
      req_q = 2'h0;
      pin = 2'h0;
      bounce[0] = 0;
      bounce[1] = 0;
   end

   // Each change of a request chatters for eight cycles, then settles
   always @(posedge mclk) begin
      for (int i = 0; i < 2; i++) begin
         if (req[i] !== req_q[i]) begin
            bounce[i] = 8;
         end
         req_q[i] = req[i];
         if (bounce[i] > 0) begin
            pin[i] <= ~pin[i];
            bounce[i]--;
         end else begin
            pin[i] <= req_q[i];
         end
      end
   end

   assign main_button     = pin[0];
   assign talkback_button = pin[1];
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "cbh_map.svh"
module tb_top;
   logic                   mclk = 1'b0;
   logic                   reset = 1'b1;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [`CBH_ADDR_W-1:0] paddr = 12'h000;
   logic [31:0]            pwdata = 32'h0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   main_req = 1'b0;
   logic                   tb_req = 1'b0;
   logic                   main_button;
   logic                   talkback_button;
   logic [6:0]             sw = 7'h06;
   logic [7:0]             pot_l = 8'h00;
   logic [7:0]             pot_r = 8'h00;
   logic                   cue_valid = 1'b0;
   logic signed [15:0]     cue_l = 16'h0000;
   logic signed [15:0]     cue_r = 16'h0000;
   logic signed [15:0]     hp_left;
   logic signed [15:0]     hp_right;
   logic                   hp_valid;
   logic                   main_active;
   logic                   talkback_active;
   logic [31:0]            rd;
   logic [3:0]             ef;
   int                     mismatches = 0;
   int                     n_checks = 0;
   int                     cyc = 0;
   int                     lat [2] = '{0, 0};
   int                     kl, kr, el, er, xl, xr;

   always #5 mclk = ~mclk;

   cbh_console #(.TICK_CYCLES(10)) u_dut (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .main_button(main_button),
      .talkback_button(talkback_button),
      .mono_headphone_select(sw[6]), .minimum_level_select(sw[5]),
      .orientation_reverse_select(sw[4]), .control_pairing_select(sw[3]),
      .talkback_button_mode_select(sw[2]),
      .main_button_mode_bit_b(sw[1]), .main_button_mode_bit_a(sw[0]),
      .pot_left(pot_l), .pot_right(pot_r), .cue_valid(cue_valid),
      .cue_left(cue_l), .cue_right(cue_r), .hp_valid(hp_valid),
      .hp_left(hp_left), .hp_right(hp_right), .main_active(main_active),
      .talkback_active(talkback_active));

   cbh_panel_model u_panel (
      .mclk(mclk), .main_req(main_req), .talkback_req(tb_req),
      .main_button(main_button), .talkback_button(talkback_button));

   task automatic test_done();
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // One APB transfer; read data lands in rd
   task automatic apb(input logic wr, input logic [`CBH_ADDR_W-1:0] a,
                      input logic [31:0] d, input logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Wait for the answer; only the cycle ceiling ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, err);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reference headphone gains from control positions and settings
   function automatic void gains(input int pl, pr, pair, rev, lim,
                                 output int gl, gr);
      int a, b, t;
      a = (pr < 128) ? 255 : 2 * (255 - pr);
      b = (pr < 128) ? 2 * pr : 255;
      gl = pair ? pl * a / 256 : pl;
      gr = pair ? pl * b / 256 : pr;
      t = gl;
      if (rev)
         gl = gr;
      if (rev)
         gr = t;
      if (lim && gl < 3)
         gl = 3;
      if (lim && gr < 3)
         gr = 3;
   endfunction

   // Reference decision for one press and release, then drive it
   task automatic press(input int w, input int m, input int tap);
      int eh, e_r;
      case (m)
         0: begin
            eh = 0;
            e_r = 1;
         end
         1: begin
            eh = 1;
            e_r = 0;
         end
         2: begin
            lat[w] = !lat[w];
            eh = lat[w];
            e_r = lat[w];
         end
         default: begin
            eh = 1;
            lat[w] = tap ? !lat[w] : 0;
            e_r = lat[w];
         end
      endcase
      if (w) tb_req <= 1'b1; else main_req <= 1'b1;
      wt(tap ? 160 : 600);
      chk(w ? talkback_active : main_active, eh);
      if (w) tb_req <= 1'b0; else main_req <= 1'b0;
      wt(160);
      chk(w ? talkback_active : main_active, e_r);
   endtask

   // Cycle ceiling against a hung bench
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'h68B8));
      wt(3);
      reset <= 1'b0;
      wt(8);
      chk(main_active, 0);
      chk(talkback_active, 0);
      apb(1'b0, `CBH_REG_MAP, 32'h0, 1'b0);
      chk(rd, 32'h000000E4);
      apb(1'b0, `CBH_REG_TAP, 32'h0, 1'b0);
      chk(rd, 32'h0000012C);
      apb(1'b0, 12'h00C, 32'h0, 1'b1);
      apb(1'b1, `CBH_REG_STAT, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, `CBH_REG_TAP, 32'h0000001E, 1'b0);
      for (int m = 0; m < 4; m++) begin
         sw[1:0] <= 2'h1;
         wt(8);
         sw[1:0] <= m[1:0];
         lat[0] = 0;
         wt(8);
         chk(main_active, m == 0);
         press(0, m, 1);
         press(0, m, 1);
         press(0, m, 0);
      end
      for (int t = 0; t < 2; t++) begin
         sw[2] <= t[0];
         lat[1] = 0;
         wt(8);
         chk(talkback_active, 0);
         press(1, 2 * t + 1, 1);
         press(1, 2 * t + 1, 1);
         press(1, 2 * t + 1, 0);
      end
      // Remapped codes: code zero now means push to talk
      apb(1'b1, `CBH_REG_MAP, 32'h000000E1, 1'b0);
      sw[1:0] <= 2'h0;
      lat[0] = 0;
      wt(8);
      chk(main_active, 0);
      press(0, 1, 1);
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, `CBH_REG_MAP, (i < 16) ? 32'hE4 : 32'h1FE4, 1'b0);
         sw[6:3] <= i[3:0];
         pot_l <= (i % 4 == 0) ? 8'h00 : 8'($urandom);
         pot_r <= (i % 8 == 2) ? 8'hFF : 8'($urandom);
         kl = int'($urandom % 100) - 50;
         kr = int'($urandom % 100) - 50;
         cue_l <= 16'(kl * 256);
         cue_r <= 16'(kr * 256);
         wt(6);
         ef = i[3:0] ^ ((i < 16) ? 4'h0 : 4'hF);
         gains(pot_l, pot_r, ef[0], ef[1], ef[2], xl, xr);
         apb(1'b0, `CBH_REG_STAT, 32'h0, 1'b0);
         chk(rd[10:4], sw);
         chk(rd[23:16], xl);
         chk(rd[31:24], xr);
         @(posedge mclk) cue_valid <= 1'b1;
         @(posedge mclk) cue_valid <= 1'b0;
         @(negedge mclk);
         el = ef[3] ? kl * xl + kr * xr : kl * xl;
         er = ef[3] ? el : kr * xr;
         chk(hp_valid, 1);
         chk(32'(hp_left), el);
         chk(32'(hp_right), er);
      end
      test_done();
   end
endmodule
